// ---- remote_ser_model.sv ----
// forward-channel side of a remote serializer: configuration load frames.
// assumes the bench calls send_cfg from its own falling-edge driven flow.
`timescale 1ns/1ps
`default_nettype none
module remote_ser_model (
  // clock
  input wire logic sys_clk_in,
  // forward-channel configuration
  output logic fc_valid_out,
  output logic [1:0] fc_port_out,
  output logic [1:0] fc_count_out,
  output logic [6:0] fc_id_out
);
  initial begin
    fc_valid_out = 1'b0;
    fc_port_out = 2'h0;
    fc_count_out = 2'h0;
    fc_id_out = 7'h00;
  end
  // =========================================================================
  // one frame
  // lines scrambled after the strobe so stale data cannot pass for a load
  task automatic send_cfg(input logic [1:0] p, input logic [1:0] c, input logic [6:0] id);
    @(negedge sys_clk_in);
    fc_valid_out = 1'b1;
    fc_port_out = p;
    fc_count_out = c;
    fc_id_out = id;
    @(negedge sys_clk_in);
    fc_valid_out = 1'b0;
    fc_port_out = ~p;
    fc_count_out = ~c;
    fc_id_out = ~id;
  endtask
endmodule
`default_nettype wire

// ---- rx_port_regs_pkg.sv ----
// Operation
// - each receive port owns its copy; port select picks the copy accessed
// - override bit set blocks forward-channel loading of datapath control
// - gpio count 00 none, 01 one, 10 two, 11 four gpios
// - gpio count loaded remotely; local write accepted only while override set
// - serializer identifier bits 7:1 auto-loaded from the remote serializer
// - freeze bit set stops identifier auto-load, keeps software value
// - serializer alias match remaps transaction to the identifier address
// - serializer alias of zero disables remote access through it
// - auto-ack bit set acknowledges every write to the remote serializer
// - forward on decode match only while pass-through enable is set
//
// constants for the per-port remote identity and alias register group.
// assumes a local register port that already resolved the i2c protocol.
package rx_port_regs_pkg;

  // ==========================================================================
  // geometry
  localparam int unsigned PORT_W = 2;
  localparam int unsigned REG_W = 8;
  localparam int unsigned I2C_ADDR_W = 7;
  localparam int unsigned NUM_TARGETS = 2;
  localparam int unsigned GPIO_MASK_W = 4;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_GPIO_CTL = 8'h59;
  localparam logic [7:0] ADDR_REMOTE_SERIALIZER_IDENTIFIER = 8'h5B;
  localparam logic [7:0] ADDR_SER_ALIAS = 8'h5C;
  localparam logic [7:0] ADDR_TGT_ZERO = 8'h5D;
  localparam logic [7:0] ADDR_TGT_ONE = 8'h5E;

  // ==========================================================================
  // fields and reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam int unsigned BIT_OVERRIDE = 7;
  localparam int unsigned BIT_FREEZE = 0;
  localparam int unsigned BIT_AUTOACK = 0;
  localparam int unsigned ADDR_LSB = 1;
  localparam int unsigned GPIO_LSB = 0;
  localparam int unsigned GPIO_W = 2;
  localparam logic [7:0] GPIO_CTL_RD_MASK = 8'h83;
  localparam logic [6:0] ALIAS_OFF = 7'h00;

  // ==========================================================================
  // gpio count encodings
  localparam logic [1:0] GPIO_CNT_NONE = 2'h0;
  localparam logic [1:0] GPIO_CNT_ONE = 2'h1;
  localparam logic [1:0] GPIO_CNT_TWO = 2'h2;
  localparam logic [3:0] GPIO_MASK_NONE = 4'h0;
  localparam logic [3:0] GPIO_MASK_ONE = 4'h1;
  localparam logic [3:0] GPIO_MASK_TWO = 4'h3;
  localparam logic [3:0] GPIO_MASK_FOUR = 4'hF;

  function automatic logic [3:0] gpio_mask_f(input logic [1:0] cnt);
    unique case (cnt)
      GPIO_CNT_NONE: gpio_mask_f = GPIO_MASK_NONE;
      GPIO_CNT_ONE: gpio_mask_f = GPIO_MASK_ONE;
      GPIO_CNT_TWO: gpio_mask_f = GPIO_MASK_TWO;
      default: gpio_mask_f = GPIO_MASK_FOUR;
    endcase
  endfunction

endpackage

// ---- rx_port_remote_i2c_id_regs.sv ----
// per-port gpio datapath control, remote identifier and alias remapping.
// assumes a decoded local register port and decoded i2c transaction requests.
`timescale 1ns/1ps
`default_nettype none

module rx_port_remote_i2c_id_regs #(
  parameter int unsigned NPORTS = 4
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // local register port
  input wire logic [rx_port_regs_pkg::PORT_W-1:0] port_select_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // forward-channel configuration load
  input wire logic fc_load_valid_in,
  input wire logic [rx_port_regs_pkg::PORT_W-1:0] fc_load_port_in,
  input wire logic [1:0] fc_gpio_count_in,
  input wire logic [6:0] fc_remote_serializer_identifier_in,
  // i2c transaction decode
  input wire logic txn_valid_in,
  input wire logic txn_write_in,
  input wire logic [rx_port_regs_pkg::PORT_W-1:0] txn_port_in,
  input wire logic [6:0] txn_addr_in,
  input wire logic [NPORTS-1:0] pass_enable_in,
  input wire logic [NPORTS*14-1:0] target_alias_in,
  // forwarded transaction and acknowledge
  output logic fwd_valid_out,
  output logic [rx_port_regs_pkg::PORT_W-1:0] fwd_port_out,
  output logic [6:0] fwd_addr_out,
  output logic autoack_out,
  // gpio enables, four per port
  output logic [NPORTS*4-1:0] gpio_enable_out
);

  // ==========================================================================
  // parameter check
  // refused at elaboration, so a bad port count never reaches simulation
  if (NPORTS < 1 || NPORTS > (1 << rx_port_regs_pkg::PORT_W)) begin : nports_check
    $error("NPORTS out of range for the port index width");
  end

  // two target aliases per port on the alias bus
  localparam int unsigned ALIAS_STRIDE =
    rx_port_regs_pkg::NUM_TARGETS * rx_port_regs_pkg::I2C_ADDR_W;

  // ==========================================================================
  // storage
  logic [7:0] gpio_ctl_q [NPORTS];
  logic [7:0] gpio_ctl_d [NPORTS];
  logic [7:0] remote_serializer_identifier_q [NPORTS];
  logic [7:0] remote_serializer_identifier_d [NPORTS];
  logic [7:0] alias_q [NPORTS];
  logic [7:0] alias_d [NPORTS];
  logic [7:0] tgt0_q [NPORTS];
  logic [7:0] tgt0_d [NPORTS];
  logic [7:0] tgt1_q [NPORTS];
  logic [7:0] tgt1_d [NPORTS];

  function automatic logic [NPORTS-1:0] onehot_f(input logic [rx_port_regs_pkg::PORT_W-1:0] idx);
    logic [NPORTS-1:0] v;
    v = '0;
    for (int p = 0; p < NPORTS; p++) begin
      v[p] = (idx == rx_port_regs_pkg::PORT_W'(p));
    end
    onehot_f = v;
  endfunction

  function automatic logic port_ok_f(input logic [rx_port_regs_pkg::PORT_W-1:0] idx);
    port_ok_f = (int'(idx) < NPORTS);
  endfunction

  function automatic logic [6:0] addr_field_f(input logic [7:0] r);
    addr_field_f = r[rx_port_regs_pkg::ADDR_LSB +: rx_port_regs_pkg::I2C_ADDR_W];
  endfunction

  // reserved low bit of the target registers always stored as zero
  wire logic [7:0] tgt_wdata_w = {addr_field_f(reg_wdata_in),
    {rx_port_regs_pkg::ADDR_LSB{1'b0}}};

  // ==========================================================================
  // decode
  wire logic [NPORTS-1:0] wr_hit_w = reg_wr_in ? onehot_f(port_select_in) : '0;
  wire logic [NPORTS-1:0] fc_hit_w = fc_load_valid_in ? onehot_f(fc_load_port_in) : '0;
  wire logic wr_gpio_w = (reg_addr_in == rx_port_regs_pkg::ADDR_GPIO_CTL);
  wire logic wr_id_w = (reg_addr_in == rx_port_regs_pkg::ADDR_REMOTE_SERIALIZER_IDENTIFIER);
  wire logic wr_alias_w = (reg_addr_in == rx_port_regs_pkg::ADDR_SER_ALIAS);
  wire logic wr_tgt0_w = (reg_addr_in == rx_port_regs_pkg::ADDR_TGT_ZERO);
  wire logic wr_tgt1_w = (reg_addr_in == rx_port_regs_pkg::ADDR_TGT_ONE);

  // ==========================================================================
  // next-state; local write beats a same-cycle load on the same field
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      gpio_ctl_d[p] = gpio_ctl_q[p];
      remote_serializer_identifier_d[p] = remote_serializer_identifier_q[p];
      alias_d[p] = alias_q[p];
      tgt0_d[p] = tgt0_q[p];
      tgt1_d[p] = tgt1_q[p];
      if (fc_hit_w[p] && !gpio_ctl_q[p][rx_port_regs_pkg::BIT_OVERRIDE]) begin
        gpio_ctl_d[p][rx_port_regs_pkg::GPIO_LSB +: rx_port_regs_pkg::GPIO_W] = fc_gpio_count_in;
      end
      if (fc_hit_w[p] && !remote_serializer_identifier_q[p][rx_port_regs_pkg::BIT_FREEZE]) begin
        remote_serializer_identifier_d[p][rx_port_regs_pkg::ADDR_LSB +: rx_port_regs_pkg::I2C_ADDR_W] = fc_remote_serializer_identifier_in;
      end
      if (wr_hit_w[p] && wr_gpio_w) begin
        gpio_ctl_d[p][rx_port_regs_pkg::BIT_OVERRIDE] =
          reg_wdata_in[rx_port_regs_pkg::BIT_OVERRIDE];
        if (gpio_ctl_q[p][rx_port_regs_pkg::BIT_OVERRIDE]) begin
          gpio_ctl_d[p][rx_port_regs_pkg::GPIO_LSB +: rx_port_regs_pkg::GPIO_W] =
            reg_wdata_in[rx_port_regs_pkg::GPIO_LSB +: rx_port_regs_pkg::GPIO_W];
        end
      end
      if (wr_hit_w[p] && wr_id_w) begin
        remote_serializer_identifier_d[p] = reg_wdata_in;
      end
      if (wr_hit_w[p] && wr_alias_w) begin
        alias_d[p] = reg_wdata_in;
      end
      if (wr_hit_w[p] && wr_tgt0_w) begin
        tgt0_d[p] = tgt_wdata_w;
      end
      if (wr_hit_w[p] && wr_tgt1_w) begin
        tgt1_d[p] = tgt_wdata_w;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    for (int p = 0; p < NPORTS; p++) begin
      gpio_ctl_q[p] <= rst_n_in ? gpio_ctl_d[p] : rx_port_regs_pkg::REG_RESET;
      remote_serializer_identifier_q[p] <= rst_n_in ? remote_serializer_identifier_d[p] : rx_port_regs_pkg::REG_RESET;
      alias_q[p] <= rst_n_in ? alias_d[p] : rx_port_regs_pkg::REG_RESET;
      tgt0_q[p] <= rst_n_in ? tgt0_d[p] : rx_port_regs_pkg::REG_RESET;
      tgt1_q[p] <= rst_n_in ? tgt1_d[p] : rx_port_regs_pkg::REG_RESET;
    end
  end

  // ==========================================================================
  // register read; a port index of NPORTS or more reads as unmapped
  wire logic rd_port_ok_w = port_ok_f(port_select_in);
  wire logic [rx_port_regs_pkg::PORT_W-1:0] rd_idx_w = rd_port_ok_w ? port_select_in : '0;
  logic [7:0] rd_data_w;
  always_comb begin
    unique case (reg_addr_in)
      rx_port_regs_pkg::ADDR_GPIO_CTL:
        rd_data_w = gpio_ctl_q[rd_idx_w] & rx_port_regs_pkg::GPIO_CTL_RD_MASK;
      rx_port_regs_pkg::ADDR_REMOTE_SERIALIZER_IDENTIFIER: rd_data_w = remote_serializer_identifier_q[rd_idx_w];
      rx_port_regs_pkg::ADDR_SER_ALIAS: rd_data_w = alias_q[rd_idx_w];
      rx_port_regs_pkg::ADDR_TGT_ZERO: rd_data_w = tgt0_q[rd_idx_w];
      rx_port_regs_pkg::ADDR_TGT_ONE: rd_data_w = tgt1_q[rd_idx_w];
      default: rd_data_w = rx_port_regs_pkg::RD_UNMAPPED;
    endcase
    if (!rd_port_ok_w) begin
      rd_data_w = rx_port_regs_pkg::RD_UNMAPPED;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    reg_rvalid_out <= rst_n_in && reg_rd_in;
    reg_rdata_out <= (rst_n_in && reg_rd_in) ? rd_data_w : rx_port_regs_pkg::RD_UNMAPPED;
  end

  // ==========================================================================
  // transaction alias decode; serializer alias takes priority over targets
  wire logic tp_ok_w = port_ok_f(txn_port_in);
  wire logic [rx_port_regs_pkg::PORT_W-1:0] tp_w = tp_ok_w ? txn_port_in : '0;
  wire logic [6:0] ser_alias_w = addr_field_f(alias_q[tp_w]);
  wire logic [6:0] tgt_alias0_w =
    target_alias_in[int'(tp_w) * ALIAS_STRIDE +: rx_port_regs_pkg::I2C_ADDR_W];
  wire logic [6:0] tgt_alias1_w =
    target_alias_in[int'(tp_w) * ALIAS_STRIDE + rx_port_regs_pkg::I2C_ADDR_W
      +: rx_port_regs_pkg::I2C_ADDR_W];
  wire logic ser_hit_w = tp_ok_w && ser_alias_w != rx_port_regs_pkg::ALIAS_OFF
    && txn_addr_in == ser_alias_w;
  wire logic tgt0_hit_w = tp_ok_w && tgt_alias0_w != rx_port_regs_pkg::ALIAS_OFF
    && txn_addr_in == tgt_alias0_w;
  wire logic tgt1_hit_w = tp_ok_w && tgt_alias1_w != rx_port_regs_pkg::ALIAS_OFF
    && txn_addr_in == tgt_alias1_w;
  wire logic any_hit_w = ser_hit_w || tgt0_hit_w || tgt1_hit_w;
  wire logic [6:0] remap_w = ser_hit_w ? addr_field_f(remote_serializer_identifier_q[tp_w])
    : (tgt0_hit_w ? addr_field_f(tgt0_q[tp_w]) : addr_field_f(tgt1_q[tp_w]));
  wire logic fwd_d_w = txn_valid_in && any_hit_w && pass_enable_in[tp_w];
  wire logic ack_d_w = txn_valid_in && txn_write_in && ser_hit_w
    && alias_q[tp_w][rx_port_regs_pkg::BIT_AUTOACK];

  always_ff @(posedge sys_clk_in) begin
    fwd_valid_out <= rst_n_in && fwd_d_w;
    fwd_port_out <= rst_n_in ? tp_w : '0;
    fwd_addr_out <= (rst_n_in && fwd_d_w) ? remap_w : rx_port_regs_pkg::ALIAS_OFF;
    autoack_out <= rst_n_in && ack_d_w;
  end

  // ==========================================================================
  // gpio enable masks
  always_ff @(posedge sys_clk_in) begin
    for (int p = 0; p < NPORTS; p++) begin
      gpio_enable_out[p*rx_port_regs_pkg::GPIO_MASK_W +: rx_port_regs_pkg::GPIO_MASK_W] <=
        rst_n_in ? rx_port_regs_pkg::gpio_mask_f(
        gpio_ctl_q[p][rx_port_regs_pkg::GPIO_LSB +: rx_port_regs_pkg::GPIO_W]) : '0;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  wire logic [7:0] fc_ctl_w = gpio_ctl_q[fc_load_port_in];
  wire logic [7:0] fc_id_w = remote_serializer_identifier_q[fc_load_port_in];
  wire logic fc_ok_w = port_ok_f(fc_load_port_in);
  wire logic coll_w = reg_wr_in && port_select_in == fc_load_port_in;

  sequence fwd_then_addr_s(logic [6:0] a);
    fwd_valid_out && fwd_addr_out == a;
  endsequence

  sel_write_a: assert property (reg_wr_in && wr_id_w && rd_port_ok_w |=>
    remote_serializer_identifier_q[$past(port_select_in)] == $past(reg_wdata_in))
    else $error("identifier write did not reach the selected port");
  override_hold_a: assert property (fc_load_valid_in && fc_ok_w && !coll_w
    && fc_ctl_w[7] |=> gpio_ctl_q[$past(fc_load_port_in)] == $past(fc_ctl_w))
    else $error("forward load changed gpio control under override");
  gpio_mask_a: assert property (gpio_enable_out[3:0] ==
    rx_port_regs_pkg::gpio_mask_f($past(gpio_ctl_q[0][1:0])))
    else $error("gpio enable mask does not match count field");
  gpio_lock_a: assert property (reg_wr_in && wr_gpio_w && rd_port_ok_w
    && !gpio_ctl_q[port_select_in][7] && !fc_load_valid_in
    |=> gpio_ctl_q[$past(port_select_in)][1:0] == $past(gpio_ctl_q[port_select_in][1:0]))
    else $error("gpio count written without override");
  id_load_a: assert property (fc_load_valid_in && fc_ok_w && !coll_w && !fc_id_w[0]
    |=> remote_serializer_identifier_q[$past(fc_load_port_in)][7:1] == $past(fc_remote_serializer_identifier_in))
    else $error("identifier not auto-loaded");
  id_freeze_a: assert property (fc_load_valid_in && fc_ok_w && !coll_w && fc_id_w[0]
    |=> remote_serializer_identifier_q[$past(fc_load_port_in)] == $past(fc_id_w))
    else $error("frozen identifier was overwritten");
  ser_remap_a: assert property (txn_valid_in && ser_hit_w && pass_enable_in[tp_w]
    |=> fwd_then_addr_s($past(remote_serializer_identifier_q[tp_w][7:1])))
    else $error("serializer alias not remapped to identifier");
  alias_off_a: assert property (txn_valid_in && ser_alias_w == rx_port_regs_pkg::ALIAS_OFF
    && !tgt0_hit_w && !tgt1_hit_w |=> !fwd_valid_out)
    else $error("zero alias forwarded a transaction");
  auto_ack_a: assert property (txn_valid_in && txn_write_in && ser_hit_w
    |=> autoack_out == $past(alias_q[tp_w][0]))
    else $error("auto-acknowledge does not follow its enable");
  tgt_remap_a: assert property (txn_valid_in && tgt0_hit_w && !ser_hit_w
    && pass_enable_in[tp_w] |=> fwd_then_addr_s($past(tgt0_q[tp_w][7:1])))
    else $error("target alias not remapped to physical address");
  pass_gate_a: assert property (txn_valid_in && !pass_enable_in[tp_w]
    |=> !fwd_valid_out)
    else $error("forwarded while pass-through disabled");

endmodule

`default_nettype wire

// ---- rx_port_remote_i2c_id_regs_bench.sv ----
// self-checking bench for the per-port remote identity register group.
// assumes three receive ports, so select value 3 is an absent port.
`timescale 1ns/1ps
`default_nettype none
module rx_port_remote_i2c_id_regs_bench;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] port_sel = 2'h0, txn_p = 2'h0, fcp, fcc, fwd_p;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
  logic txn_v = 1'b0, txn_w = 1'b1, fcv, rvalid, fwd_v, ack;
  logic [6:0] txn_a = 7'h00, fci, fwd_a;
  logic [2:0] pass_en = 3'h0;
  logic [41:0] tgt_alias = 42'h0;
  logic [11:0] gpio;
  int fail_count = 0, num_checks = 0;
  always #2 clk = ~clk;
  remote_ser_model ser (.sys_clk_in(clk), .fc_valid_out(fcv), .fc_port_out(fcp),
    .fc_count_out(fcc), .fc_id_out(fci));
  rx_port_remote_i2c_id_regs #(.NPORTS(3)) dut (.sys_clk_in(clk), .rst_n_in(rst_n),
    .port_select_in(port_sel), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .fc_load_valid_in(fcv), .fc_load_port_in(fcp),
    .fc_gpio_count_in(fcc), .fc_remote_serializer_identifier_in(fci), .txn_valid_in(txn_v),
    .txn_write_in(txn_w), .txn_port_in(txn_p), .txn_addr_in(txn_a),
    .pass_enable_in(pass_en), .target_alias_in(tgt_alias), .fwd_valid_out(fwd_v),
    .fwd_port_out(fwd_p), .fwd_addr_out(fwd_a), .autoack_out(ack),
    .gpio_enable_out(gpio));
  // =========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    port_sel = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    port_sel = p;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({7'h00, rvalid}, 8'h01, "read valid");
    chk(rdata, e, "read data");
  endtask
  task automatic txn_chk(input logic [1:0] p, input logic w, input logic [6:0] a,
    input logic f, input logic [6:0] fa, input logic k);
    @(negedge clk);
    txn_p = p;
    txn_w = w;
    txn_a = a;
    txn_v = 1'b1;
    @(negedge clk);
    txn_v = 1'b0;
    chk({7'h00, fwd_v}, {7'h00, f}, "forward valid");
    chk({1'b0, fwd_a}, {1'b0, fa}, "forward address");
    chk({6'h00, fwd_p}, {6'h00, p}, "forward port");
    chk({7'h00, ack}, {7'h00, k}, "auto ack");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // =========================================================================
  // scenarios
  task automatic t_reset();
    logic [7:0] addrs [6] = '{8'h59, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5A};
    foreach (addrs[i]) rd_chk(2'h0, addrs[i], 8'h00);
    chk(gpio[7:0], 8'h00, "gpio after reset");
    $display("test reset done");
  endtask
  task automatic t_gpio();
    logic [3:0] masks [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    ser.send_cfg(2'h1, 2'h2, 7'h00);
    rd_chk(2'h1, 8'h59, 8'h02);
    chk({4'h0, gpio[7:4]}, 8'h03, "gpio two");
    wr(2'h1, 8'h59, 8'h03);
    rd_chk(2'h1, 8'h59, 8'h02);
    wr(2'h1, 8'h59, 8'h80);
    wr(2'h1, 8'h59, 8'h83);
    rd_chk(2'h1, 8'h59, 8'h83);
    ser.send_cfg(2'h1, 2'h1, 7'h00);
    rd_chk(2'h1, 8'h59, 8'h83);
    for (int i = 0; i < 4; i++) begin
      wr(2'h1, 8'h59, 8'hFC | 8'(i));
      @(negedge clk);
      chk({4'h0, gpio[7:4]}, {4'h0, masks[i]}, "gpio mask");
      rd_chk(2'h1, 8'h59, 8'h80 | 8'(i));
    end
    chk({4'h0, gpio[3:0]}, 8'h00, "other port gpio");
    $display("test gpio done");
  endtask
  task automatic t_serid();
    ser.send_cfg(2'h0, 2'h0, 7'h2A);
    rd_chk(2'h0, 8'h5B, 8'h54);
    wr(2'h0, 8'h5B, 8'h11);
    ser.send_cfg(2'h0, 2'h0, 7'h2A);
    rd_chk(2'h0, 8'h5B, 8'h11);
    $display("test identifier done");
  endtask
  task automatic t_ports();
    wr(2'h0, 8'h5D, 8'h45);
    rd_chk(2'h2, 8'h5D, 8'h00);
    wr(2'h3, 8'h5D, 8'hFF);
    rd_chk(2'h3, 8'h5D, 8'h00);
    rd_chk(2'h0, 8'h5D, 8'h44);
    $display("test ports done");
  endtask
  task automatic t_remap();
    pass_en = 3'h1;
    wr(2'h0, 8'h5C, 8'h31);
    txn_chk(2'h0, 1'b1, 7'h18, 1'b1, 7'h08, 1'b1);
    pass_en = 3'h0;
    txn_chk(2'h0, 1'b1, 7'h18, 1'b0, 7'h00, 1'b1);
    pass_en = 3'h1;
    tgt_alias[13:0] = {7'h31, 7'h30};
    txn_chk(2'h0, 1'b1, 7'h30, 1'b1, 7'h22, 1'b0);
    wr(2'h0, 8'h5E, 8'h66);
    txn_chk(2'h0, 1'b1, 7'h31, 1'b1, 7'h33, 1'b0);
    wr(2'h0, 8'h5C, 8'h30);
    txn_chk(2'h0, 1'b1, 7'h18, 1'b1, 7'h08, 1'b0);
    wr(2'h0, 8'h5C, 8'h00);
    txn_chk(2'h0, 1'b1, 7'h00, 1'b0, 7'h00, 1'b0);
    $display("test remap done");
  endtask
  task automatic t_txn_ports();
    pass_en = 3'h7;
    wr(2'h1, 8'h5B, 8'h21);
    wr(2'h1, 8'h5C, 8'h31);
    txn_chk(2'h1, 1'b0, 7'h18, 1'b1, 7'h10, 1'b0);
    txn_chk(2'h1, 1'b1, 7'h18, 1'b1, 7'h10, 1'b1);
    txn_chk(2'h2, 1'b1, 7'h18, 1'b0, 7'h00, 1'b0);
    $display("test transaction ports done");
  endtask
  task automatic t_mid_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(gpio[7:0], 8'h00, "gpio low ports after reset");
    chk({4'h0, gpio[11:8]}, 8'h00, "gpio high port after reset");
    rd_chk(2'h1, 8'h59, 8'h00);
    rd_chk(2'h1, 8'h5B, 8'h00);
    rd_chk(2'h1, 8'h5C, 8'h00);
    rd_chk(2'h0, 8'h5E, 8'h00);
    $display("test mid-run reset done");
  endtask
  // =========================================================================
  // main flow and watchdog
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_gpio();
    t_serid();
    t_ports();
    t_remap();
    t_txn_ports();
    t_mid_reset();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
